// File: rtl/cwbb_pkg.sv
// constants and types of the external interface unit with its collapsing write buffer
// How it works
// R1 - two 16-byte halves: one drains to the bus, the other gathers stores
// R2 - flush gathering half on new block, barrier, bad merge, uncached access, same-line load
// R3 - if the draining half is still busy, stall the core until it empties
// R4 - byte, half, three-byte and word stores build a 16-byte value, sent as words
// R5 - uncached stores are never merged; each is its own bus transaction
// R6 - no-merge policy: second store to a written word pushes the line out first
// R7 - full-merge policy: any store pattern to the same line is gathered
// R8 - aligned enable mode drives only 0001 0010 0100 1000 0011 1100 1111 on write beats
// R9 - aligned enable mode splits an illegal write pattern into two bus writes
// R10 - the split is done whichever merge policy is in force
// R11 - aligned enable mode turns an uncached three-byte partial load into a word read
package cwbb_pkg;
   localparam int CWBB_ADDR_W = 32;
   localparam int CWBB_DATA_W = 32;
   localparam int CWBB_LANES = 4;
   localparam int CWBB_BLOCK_BYTES = 16;
   localparam int CWBB_WORDS = CWBB_BLOCK_BYTES / CWBB_LANES;
   localparam int CWBB_BLOCK_LSB = 4;
   localparam int CWBB_WORD_LSB = 2;
   localparam logic [3:0] CWBB_BE_B0 = 4'h1;
   localparam logic [3:0] CWBB_BE_B1 = 4'h2;
   localparam logic [3:0] CWBB_BE_B2 = 4'h4;
   localparam logic [3:0] CWBB_BE_B3 = 4'h8;
   localparam logic [3:0] CWBB_BE_LO = 4'h3;
   localparam logic [3:0] CWBB_BE_HI = 4'hC;
   localparam logic [3:0] CWBB_BE_WORD = 4'hF;
   typedef enum logic [0:0] {CWBB_C_IDLE, CWBB_C_READ} cwbb_core_state_t;
endpackage

// File: rtl/cwbb_lane_if.sv
// enable pattern carried to and from the aligned pattern checker
`timescale 1ns/1ps
interface cwbb_lane_if;
   logic [3:0] pattern;
   logic legal;
   logic [3:0] first;
   modport checker_side (input pattern, output legal, output first);
   modport user_side (output pattern, input legal, input first);
endinterface

// File: rtl/cwbb_aligned_check.sv
// aligned enable pattern check and first-half split
`timescale 1ns/1ps
module cwbb_aligned_check
   import cwbb_pkg::*;
(
   cwbb_lane_if.checker_side lane
);
   wire is_byte = (lane.pattern == CWBB_BE_B0) || (lane.pattern == CWBB_BE_B1) ||
                  (lane.pattern == CWBB_BE_B2) || (lane.pattern == CWBB_BE_B3);
   wire is_half = (lane.pattern == CWBB_BE_LO) || (lane.pattern == CWBB_BE_HI);
   assign lane.legal = is_byte || is_half || (lane.pattern == CWBB_BE_WORD); // R8
   // an illegal pattern always has both halves set, so the low half goes first
   assign lane.first = {2'b00, lane.pattern[1:0]}; // R9
endmodule

// File: rtl/cwbb_external_interface_unit.sv
// external interface unit: gathering half, draining half and bus beat engine
`timescale 1ns/1ps
module cwbb_external_interface_unit
   import cwbb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic merge_full,
   input wire logic aligned_enable_mode,
   input wire logic core_req_valid,
   input wire logic core_req_write,
   input wire logic core_req_sync,
   input wire logic core_req_uncached,
   input wire logic core_req_partial,
   input wire logic [CWBB_ADDR_W-1:0] core_req_addr,
   input wire logic [CWBB_DATA_W-1:0] core_req_wdata,
   input wire logic [CWBB_LANES-1:0] core_req_be,
   output logic core_done,
   output logic [CWBB_DATA_W-1:0] core_rdata,
   output logic bus_valid,
   output logic bus_write,
   output logic [CWBB_ADDR_W-1:0] bus_addr,
   output logic [CWBB_DATA_W-1:0] bus_wdata,
   output logic [CWBB_LANES-1:0] byte_lane_enables,
   input wire logic bus_ready,
   input wire logic bus_rvalid,
   input wire logic [CWBB_DATA_W-1:0] bus_rdata
);
   localparam int BLK_W = CWBB_ADDR_W - CWBB_BLOCK_LSB;

   // ----------------------------------------
   // state
   // ----------------------------------------
   cwbb_core_state_t state;
   logic acc_valid;
   logic [BLK_W-1:0] acc_block;
   logic [CWBB_BLOCK_BYTES*8-1:0] acc_data;
   logic [CWBB_BLOCK_BYTES-1:0] acc_be;
   logic [BLK_W-1:0] drn_block;
   logic [CWBB_BLOCK_BYTES*8-1:0] drn_data;
   logic [CWBB_BLOCK_BYTES-1:0] drn_be;
   logic [CWBB_BLOCK_BYTES-1:0] beat_clr;

   // ----------------------------------------
   // request decode
   // ----------------------------------------
   wire [BLK_W-1:0] req_block = core_req_addr[CWBB_ADDR_W-1:CWBB_BLOCK_LSB];
   wire [1:0] req_word = core_req_addr[CWBB_BLOCK_LSB-1:CWBB_WORD_LSB];
   wire [CWBB_BLOCK_BYTES-1:0] req_mask = {12'h000, core_req_be} << {req_word, 2'b00};
   wire req_cached = !core_req_uncached;
   wire is_sync = core_req_sync;
   wire is_store = core_req_write && !core_req_sync;
   wire is_read = !core_req_write && !core_req_sync;
   wire is_cached_store = is_store && req_cached;
   wire is_uncached_store = is_store && core_req_uncached;

   // ----------------------------------------
   // flush reasons for the gathering half
   // ----------------------------------------
   wire acc_hit_block = (acc_block == req_block);
   wire same_line = acc_valid && acc_hit_block;
   wire [3:0] word_be = acc_be[{req_word, 2'b00} +: 4];
   wire word_written = |word_be;
   wire bad_merge = !merge_full && same_line && word_written; // R6 R7
   wire flush_new_block = is_store && !same_line; // R2
   wire flush_barrier = is_sync; // R2
   wire flush_bad_merge = is_store && bad_merge; // R2
   wire flush_uncached = core_req_uncached && (is_store || is_read); // R2 R5
   wire flush_line_load = is_read && same_line; // R2
   wire flush_any = flush_new_block || flush_barrier || flush_bad_merge || flush_uncached || flush_line_load;
   wire need_flush = acc_valid && flush_any; // R2

   // ----------------------------------------
   // request start conditions
   // ----------------------------------------
   wire drn_valid = |drn_be;
   wire drn_free = !drn_valid;
   wire take = core_req_valid && !core_done && (state == CWBB_C_IDLE);
   wire take_clean = take && !need_flush;
   wire do_move = take && need_flush && drn_free; // R1 R3
   wire sync_done = take && is_sync && !acc_valid && drn_free;
   wire unc_write = take_clean && is_uncached_store && drn_free; // R5
   wire gather = take_clean && is_cached_store; // R4
   wire rd_start = take_clean && is_read && drn_free && !bus_valid;
   wire beat_accept = bus_valid && bus_ready;
   wire beat_done = beat_accept && bus_write;

   // ----------------------------------------
   // pattern checks
   // ----------------------------------------
   cwbb_lane_if wr_lane();
   cwbb_lane_if rd_lane();
   cwbb_aligned_check u_wr_check (.lane(wr_lane.checker_side));
   cwbb_aligned_check u_rd_check (.lane(rd_lane.checker_side));

   // ----------------------------------------
   // beat selection
   // ----------------------------------------
   logic [1:0] sel_word;
   always_comb begin
      sel_word = 2'd0;
      for (int w = CWBB_WORDS - 1; w >= 0; w--) begin
         if (|drn_be[w*4 +: 4]) begin
            sel_word = 2'(w);
         end
      end
   end

   wire [3:0] sel_nib = drn_be[{sel_word, 2'b00} +: 4];
   wire [CWBB_DATA_W-1:0] sel_data = drn_data[{sel_word, 5'b00000} +: CWBB_DATA_W];
   assign wr_lane.pattern = sel_nib;
   wire wr_split = aligned_enable_mode && !wr_lane.legal; // R9
   wire [3:0] wr_pat = wr_split ? wr_lane.first : sel_nib; // R9 R10
   wire [CWBB_BLOCK_BYTES-1:0] next_beat_clr = {12'h000, wr_pat} << {sel_word, 2'b00};
   wire [CWBB_ADDR_W-1:0] beat_addr = {drn_block, sel_word, 2'b00};

   // ----------------------------------------
   // read pattern widening
   // ----------------------------------------
   assign rd_lane.pattern = core_req_be;
   wire tri_load = core_req_uncached && core_req_partial;
   wire widen = aligned_enable_mode && tri_load && !rd_lane.legal;
   wire [3:0] rd_pat = widen ? CWBB_BE_WORD : core_req_be; // R11

   // ----------------------------------------
   // launch and answer decode
   // ----------------------------------------
   wire launch_write = !bus_valid && drn_valid; // R4
   wire launch_read = !bus_valid && drn_free && rd_start;
   wire read_back = (state == CWBB_C_READ) && bus_rvalid;
   wire quick_done = sync_done || unc_write || gather; // R3

   // ----------------------------------------
   // core side
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= CWBB_C_IDLE;
         core_done <= 1'b0;
         core_rdata <= '0;
      end else begin
         core_done <= quick_done; // R3
         if (rd_start) begin
            state <= CWBB_C_READ;
         end else if (read_back) begin
            state <= CWBB_C_IDLE;
            core_done <= 1'b1;
            core_rdata <= bus_rdata;
         end
      end
   end

   // ----------------------------------------
   // gathering half
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_valid <= 1'b0;
         acc_block <= '0;
         acc_data <= '0;
         acc_be <= '0;
      end else if (do_move) begin
         acc_valid <= 1'b0; // R1
         acc_be <= '0;
      end else if (gather) begin
         acc_valid <= 1'b1; // R4
         acc_block <= req_block;
         acc_be <= acc_be | req_mask;
         for (int b = 0; b < CWBB_BLOCK_BYTES; b++) begin
            if (req_mask[b]) begin
               acc_data[b*8 +: 8] <= core_req_wdata[(b%4)*8 +: 8];
            end
         end
      end
   end

   // ----------------------------------------
   // draining half
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drn_block <= '0;
         drn_data <= '0;
         drn_be <= '0;
      end else if (do_move) begin
         drn_block <= acc_block; // R1
         drn_data <= acc_data;
         drn_be <= acc_be;
      end else if (unc_write) begin
         drn_block <= req_block; // R5
         drn_data <= {CWBB_WORDS{core_req_wdata}};
         drn_be <= req_mask;
      end else if (beat_done) begin
         drn_be <= drn_be & ~beat_clr;
      end
   end

   // ----------------------------------------
   // bus beat engine
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_valid <= 1'b0;
         bus_write <= 1'b0;
         bus_addr <= '0;
         bus_wdata <= '0;
         byte_lane_enables <= '0;
         beat_clr <= '0;
      end else if (bus_valid) begin
         if (bus_ready) begin
            bus_valid <= 1'b0;
         end
      end else if (launch_write) begin
         bus_valid <= 1'b1; // R4
         bus_write <= 1'b1;
         bus_addr <= beat_addr;
         bus_wdata <= sel_data;
         byte_lane_enables <= wr_pat; // R8
         beat_clr <= next_beat_clr;
      end else if (launch_read) begin
         bus_valid <= 1'b1;
         bus_write <= 1'b0;
         bus_addr <= core_req_addr;
         byte_lane_enables <= rd_pat; // R11
      end
   end
endmodule

// File: dv/cwbb_chk.sv
// port assertions of the external interface unit
`timescale 1ns/1ps
module cwbb_chk
   import cwbb_pkg::*;
(
   input wire logic clk, rst_n, aligned_enable_mode, core_req_valid, core_req_write,
   input wire logic core_req_sync, core_req_uncached, core_req_partial, core_done,
   input wire logic bus_valid, bus_write, bus_ready, bus_rvalid,
   input wire logic [CWBB_ADDR_W-1:0] core_req_addr, bus_addr,
   input wire logic [CWBB_DATA_W-1:0] bus_wdata,
   input wire logic [CWBB_LANES-1:0] byte_lane_enables
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic wr_beat = bus_valid && bus_write;
   wire logic rd_beat = bus_valid && !bus_write;
   property p_legal; wr_beat && aligned_enable_mode |-> byte_lane_enables inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF}; endproperty
   a_legal: assert property (p_legal) else $error("illegal enable pattern in aligned mode");
   property p_hold; bus_valid && !bus_ready |=> bus_valid && $stable({bus_write, bus_addr, bus_wdata, byte_lane_enables}); endproperty
   a_hold: assert property (p_hold) else $error("bus beat changed before acceptance");
   property p_gap; bus_valid && bus_ready |=> !bus_valid; endproperty
   a_gap: assert property (p_gap) else $error("no idle cycle after accepted beat");
   property p_word; wr_beat |-> bus_addr[1:0] == 2'h0 && byte_lane_enables != 4'h0; endproperty
   a_word: assert property (p_word) else $error("write beat not a word beat");
   property p_tri; rd_beat && aligned_enable_mode && core_req_partial && core_req_uncached |-> byte_lane_enables == 4'hF; endproperty
   a_tri: assert property (p_tri) else $error("partial load not widened");
   property p_raddr; rd_beat |-> bus_addr == core_req_addr && core_req_valid; endproperty
   a_raddr: assert property (p_raddr) else $error("read beat address wrong");
   property p_sync; core_done && core_req_valid && core_req_sync |-> !bus_valid; endproperty
   a_sync: assert property (p_sync) else $error("barrier done with bus busy");
   property p_load; core_done && core_req_valid && !core_req_write && !core_req_sync |-> $past(bus_rvalid); endproperty
   a_load: assert property (p_load) else $error("load done without read data");
   property p_pulse; core_done |=> !core_done; endproperty
   a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
endmodule
bind cwbb_external_interface_unit cwbb_chk u_chk (.*);

// File: dv/cwbb_bus_model.sv
// bus and memory partner with random ready and read latency
`timescale 1ns/1ps
module cwbb_bus_model
   import cwbb_pkg::*;
(
   input wire logic clk, rst_n, bus_valid, bus_write,
   input wire logic [CWBB_ADDR_W-1:0] bus_addr,
   output logic bus_ready, bus_rvalid,
   output logic [CWBB_DATA_W-1:0] bus_rdata
);
   logic [15:0] lf;
   logic [2:0] cnt;
   logic [31:0] ra;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lf <= 16'hACE1;
         bus_ready <= 1'b0;
         cnt <= 3'h0;
         ra <= 32'h0;
      end else begin
         lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
         bus_ready <= lf[0];
         if (bus_valid && bus_ready && !bus_write) begin
            cnt <= {1'b0, lf[2:1]} + 3'h1;
            ra <= bus_addr;
         end else if (cnt != 3'h0) cnt <= cnt - 3'h1;
      end
   end
   assign bus_rvalid = (cnt == 3'h1);
   assign bus_rdata = bus_rvalid ? ~ra : {lf, ~lf};
endmodule

// File: dv/tb.sv
// self-checking bench of the external interface unit
`timescale 1ns/1ps
module tb
   import cwbb_pkg::*;
;
   logic clk = 0, rst_n = 0, merge_full = 0, aligned_enable_mode = 0, core_req_valid = 0, core_req_write = 0;
   logic core_req_sync = 0, core_req_uncached = 0, core_req_partial = 0, core_done, bus_valid, bus_write;
   logic bus_ready, bus_rvalid;
   logic [31:0] core_req_addr = 0, core_req_wdata = 0, core_rdata, bus_addr, bus_wdata, bus_rdata;
   logic [31:0] seed = 32'hB9C23335;
   logic [3:0] core_req_be = 4'hF, byte_lane_enables;
   logic [68:0] exp_q[$];
   logic [31:0] line_d[4];
   logic [3:0] line_b[4];
   logic [27:0] blk;
   int n_fail = 0, total_checks = 0;
   cwbb_external_interface_unit DUT (.*);
   cwbb_bus_model u_mem (.*);
   initial forever #2.5 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] msk(input logic [31:0] d, input logic [3:0] b);
      for (int i = 0; i < 4; i++) if (!b[i]) d[8*i+:8] = 8'h0;
      return d;
   endfunction
   task automatic end_of_test();
      if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [68:0] got, input logic [68:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic push(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
      if (aligned_enable_mode && !(be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})) begin
         exp_q.push_back({1'b1, a, be & 4'h3, msk(d, be & 4'h3)});
         exp_q.push_back({1'b1, a, be & 4'hC, msk(d, be & 4'hC)});
      end else exp_q.push_back({1'b1, a, be, msk(d, be)});
   endtask
   task automatic flush();
      for (int w = 0; w < 4; w++) if (line_b[w] != 4'h0) push({blk, w[1:0], 2'h0}, line_d[w], line_b[w]);
      line_b = '{default: 4'h0};
   endtask
   task automatic req(input logic w, s, u, p, input logic [31:0] a, d, input logic [3:0] be);
      int n;
      @(posedge clk);
      core_req_valid <= 1; core_req_write <= w; core_req_sync <= s; core_req_uncached <= u;
      core_req_partial <= p; core_req_addr <= a; core_req_wdata <= d; core_req_be <= be;
      n = 0;
      do begin @(negedge clk); n++; end while (core_done !== 1'b1 && n < 300);
      chk({68'h0, core_done}, 69'h1);
      if (!w && !s) chk({37'h0, core_rdata}, {37'h0, ~a});
      @(posedge clk);
      core_req_valid <= 0;
   endtask
   task automatic op(input logic [31:0] r);
      logic [31:0] a, d;
      logic [3:0] be;
      a = {26'h0, r[5:2], 2'h0};
      d = rnd();
      be = (r[11:8] == 4'h0) ? 4'hF : r[11:8];
      if (r[14:12] == 3'h7) begin flush(); req(0, 1, 0, 0, a, d, be); end
      else if (r[14:12] == 3'h6) begin
         if (r[15] || a[31:4] == blk) flush();
         be = r[15] ? (r[16] ? 4'h7 : 4'hE) : 4'hF;
         exp_q.push_back({1'b0, a, (aligned_enable_mode && r[15]) ? 4'hF : be, 32'h0});
         req(0, 0, r[15], r[15], a, d, be);
      end else if (r[14:12] == 3'h5) begin flush(); push(a, d, be); req(1, 0, 1, 0, a, d, be); end
      else begin
         if (a[31:4] != blk || (!merge_full && line_b[a[3:2]] != 4'h0)) flush();
         blk = a[31:4];
         for (int i = 0; i < 4; i++) if (be[i]) line_d[a[3:2]][8*i+:8] = d[8*i+:8];
         line_b[a[3:2]] |= be;
         req(1, 0, 0, 0, a, d, be);
      end
   endtask
   always @(posedge clk) if (bus_valid && bus_ready)
      chk({bus_write, bus_addr, byte_lane_enables, bus_write ? msk(bus_wdata, byte_lane_enables) : 32'h0},
          exp_q.size() ? exp_q.pop_front() : 69'h0);
   initial begin #400000; n_fail++; end_of_test(); end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      for (int m = 0; m < 4; m++) begin
         merge_full <= m[0];
         aligned_enable_mode <= m[1];
         blk = 28'hFFFFFFF;
         line_b = '{default: 4'h0};
         @(posedge clk);
         repeat (150) op(rnd());
         flush();
         req(0, 1, 0, 0, 32'h0, 32'h0, 4'hF);
         chk(exp_q.size(), 69'h0);
         rst_n <= 0;
         @(posedge clk);
         rst_n <= 1;
      end
      end_of_test();
   end
endmodule
